// *** bench/ctl_model.sv ***
// Purpose: controller model that drives the register strobe port
// Assumes: strobes change on the falling edge and last one cycle
// Notes: released write data is inverted, so stale data cannot pass
module ctl_model (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_reg_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [3:0] o_addr,
    output logic [7:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==============================
    // bus cycles
    initial {o_wr, o_rd, o_addr, o_wdata} = '0;
    // one write; sleep, stop and stage enable go out here
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        {o_wr, o_addr, o_wdata} = {1'b1, a, d};
        @(negedge i_clk_sys);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask
    // read data is registered, so take it one cycle later
    task automatic get(input logic [3:0] a, output logic [7:0] d);
        @(negedge i_clk_sys);
        {o_rd, o_addr} = {1'b1, a};
        @(negedge i_clk_sys);
        o_rd = 1'b0;
        @(negedge i_clk_sys);
        d = i_reg_rdata;
    endtask
endmodule // ctl_model

// *** bench/tb_top.sv ***
// Purpose: self-checking bench of the mode and interrupt unit
// Assumes: short startup and reset hold counts
// Notes: expected flags kept in int mirrors
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mode_irq_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, wr, rd, hall = 1'b0, hok = 1'b0, wake = 1'b0;
    logic bdom = 1'b0, irq, ron, rlim, rstn, stg, ben, arm, wdr;
    logic [2:0] cnd = '0;
    logic [3:0] adr;
    logic [7:0] wd, rdat, got, flt = '0;
    int err_total = 0, n_checks = 0, m_ifr = 0, m_rsr = 0, k;
    always #25 clk = ~clk;
    ctl_model i_ctl (.i_clk_sys(clk), .i_reg_rdata(rdat), .o_wr(wr), .o_rd(rd),
        .o_addr(adr), .o_wdata(wd));
    mode_and_interrupt_unit #(.STARTUP_CYCLES(50), .RESET_HOLD(4)) i_dut (
        .i_clk_sys(clk), .i_nrst(nrst), .i_ce(1'b1), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(adr), .i_reg_wdata(wd), .i_undervolt(cnd[0]), .i_overvolt(cnd[1]),
        .i_over_temp(cnd[2]), .i_stage_fault(flt), .i_hall_state_flag(hall),
        .i_hall_mode_ok(hok), .i_wake_input_state_flag(wake), .i_bus_dominant(bdom),
        .i_monitor_disable(1'b0), .o_reg_rdata(rdat), .o_irq(irq), .o_regulator_on(ron),
        .o_regulator_limited(rlim), .o_reset_n(rstn), .o_stages_enable(stg),
        .o_bus_enable(ben), .o_bus_wake_armed(arm), .o_watchdog_run(wdr));
    // ==============================
    // shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want) begin
            err_total++;
            $display("mismatch at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input int want);
        i_ctl.get(a, got);
        chk(got, want[7:0]);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // pulse length, also proves no retrigger while a level stays
    task automatic icnt;
        k = 0;
        repeat (12) begin
            @(negedge clk);
            k += int'(irq);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog, the run needs about 2300 cycles
    initial begin
        #1ms;
        err_total++;
        wrap_up();
    end
    // ==============================
    // main sequence
    initial begin
        k = $urandom(68);
        cyc(10);
        nrst = 1'b1;
        cyc(8);
        chk({ron, rstn, stg, ben}, 8'hc);
        rchk(ADDR_IMR, 0);
        i_ctl.put(ADDR_IMR, 8'h7f);
        i_ctl.put(ADDR_SYSCTL, 8'h09);
        chk({stg, ben, wdr}, 8'h7);
        for (int b = 0; b < 3; b++) begin
            cnd[b] = 1'b1;
            icnt();
            chk(8'(k), 8'h4);
            i_ctl.put(ADDR_IFR, 8'h07);
            rchk(ADDR_IFR, 1 << b);
            cnd[b] = 1'b0;
            i_ctl.put(ADDR_IFR, 8'h07);
            rchk(ADDR_IFR, 0);
        end
        flt = 8'($urandom_range(255, 1));
        icnt();
        chk(8'(k), 8'h4);
        i_ctl.put(ADDR_IFR, 8'h10);
        rchk(ADDR_IFR, 8'h10);
        flt = '0;
        rchk(ADDR_IFR, 0);
        hall = 1'b1;
        cyc(3);
        rchk(ADDR_IFR, 0);
        hok = 1'b1;
        hall = 1'b0;
        wake = 1'b1;
        m_ifr = (1 << BIT_HALL) | (1 << BIT_WAKE_INPUT);
        rchk(ADDR_IFR, m_ifr);
        i_ctl.put(ADDR_IFR, 8'h00);
        rchk(ADDR_IFR, m_ifr);
        i_ctl.put(ADDR_IFR, 8'(m_ifr));
        i_ctl.put(ADDR_SYSCTL, 8'h02);
        chk({ron, rlim, rstn, stg, arm, wdr}, 8'h3a);
        cnd = 3'h7;
        flt = 8'h01;
        cyc(4);
        {cnd, flt} = '0;
        rchk(ADDR_IFR, 0);
        wake = 1'b0;
        icnt();
        chk(8'(k), 8'h4);
        rchk(ADDR_IFR, 1 << BIT_WAKE_INPUT);
        i_ctl.put(ADDR_IFR, 8'h40);
        bdom = 1'b1;
        cyc(1001);
        bdom = 1'b0;
        icnt();
        chk(8'(k), 8'h4);
        rchk(ADDR_IFR, 1 << BIT_BUS_WAKE);
        i_ctl.put(ADDR_SYSCTL, 8'h01);
        chk({stg, arm, wdr}, 8'h4);
        i_ctl.put(ADDR_SYSCTL, 8'h04);
        chk({ron, rstn, arm}, 8'h1);
        wake = 1'b1;
        cyc(3);
        chk({ron, rstn, arm}, 8'h4);
        m_rsr = 1 << BIT_WAKE_INPUT_WAKEUP;
        rchk(ADDR_RSR, m_rsr);
        rchk(ADDR_IMR, 0);
        cyc(60);
        chk({ron, rstn, arm}, 8'h1);
        bdom = 1'b1;
        cyc(1001);
        bdom = 1'b0;
        cyc(8);
        m_rsr |= 1 << BIT_BUS_ACTIVITY_WAKEUP;
        rchk(ADDR_RSR, m_rsr);
        i_ctl.put(ADDR_RSR, 8'h01);
        rchk(ADDR_RSR, m_rsr & 2);
        wrap_up();
    end
endmodule // tb_top

// *** hw/irq_pulse_gen.sv ***
// Purpose: fixed-length interrupt pulse from a one-cycle trigger
// Assumes: trigger is a single-cycle event
// Notes: a new trigger during a pulse restarts its length
module irq_pulse_gen (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_ce,
    pulse_link_if.dst lnk
);
    import mode_irq_pkg::*;
    typedef struct packed {
        logic [2:0] cnt; // cycles left after this one
        logic pulse; // interrupt line level
    } ip_state_type;
    ip_state_type s_reg;
    ip_state_type s_next;
    // ==================================================================
    // next state
    always_comb begin
        s_next = s_reg;
        if (lnk.trigger) begin
            s_next.cnt = 3'(IRQ_PULSE_CYCLES - 1);
            s_next.pulse = 1'b1;
        end else if (s_reg.cnt != 3'h0) begin
            s_next.cnt = s_reg.cnt - 3'h1;
        end else begin
            s_next.pulse = 1'b0;
        end
    end
    // ==================================================================
    // state register
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            s_reg <= '0;
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end
    assign lnk.pulse = s_reg.pulse;
endmodule // irq_pulse_gen

// *** hw/mode_and_interrupt_unit.sv ***
// Purpose: operating modes, wake-up and interrupt flags of the companion die
// Assumes: register strobes and sensor levels synchronous to i_clk_sys
// Notes: i_nrst is the power-on reset; a wake from sleep acts like it
// How it works
// - sleep: regulator off, reset low, bus listens
// - sleep bit write sends device to sleep
// - sleep wakes on bus or wake input, unmasked
// - sleep wake resets and records its source
// - normal request: reset high, stages and bus off
// - normal: stages, bus on, watchdog if enabled
// - stop: limited regulator, no watchdog, no stages
// - seven maskable sources pulse the interrupt pin
// - every enable cleared after any reset
// - undervoltage sets flag, interrupt if enabled
// - overvoltage sets flag, interrupt if enabled
// - over temperature sets flag, interrupt if enabled
// - stop and sleep disable five detectors
// - stop: long dominant then rising edge flags bus
// - any output fault sets stage fault flag
// - hall edges flagged when input mode allows
// - wake input edges set its change flag
// - change and bus flags clear on one
// - active condition blocks clearing its flag
// - stage fault flag read-only, or of faults
// - missing stage enable in time forces sleep
// - stop wake gated by enables, reported by interrupt
// - wake source flags clear only by one
module mode_and_interrupt_unit #(
    parameter int unsigned STARTUP_CYCLES = mode_irq_pkg::STARTUP_MONITOR_TIMEOUT_CYCLES,
    parameter int unsigned RESET_HOLD = mode_irq_pkg::RESET_HOLD_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_undervolt,
    input wire logic i_overvolt,
    input wire logic i_over_temp,
    input wire logic [mode_irq_pkg::NUM_FAULT-1:0] i_stage_fault,
    input wire logic i_hall_state_flag,
    input wire logic i_hall_mode_ok,
    input wire logic i_wake_input_state_flag,
    input wire logic i_bus_dominant,
    input wire logic i_monitor_disable,
    output logic [7:0] o_reg_rdata,
    output logic o_irq,
    output logic o_regulator_on,
    output logic o_regulator_limited,
    output logic o_reset_n,
    output logic o_stages_enable,
    output logic o_bus_enable,
    output logic o_bus_wake_armed,
    output logic o_watchdog_run
);
    import mode_irq_pkg::*;
    // ==================================================================
    // state
    typedef struct packed {
        mode_type mode; // operating mode
        logic [CNT_W-1:0] cnt; // reset hold / startup monitor time
        logic [NUM_SRC-1:0] en; // interrupt enables
        logic [NUM_SRC-1:0] flag; // interrupt flags
        logic [1:0] wkf; // wake source flags
        logic stage_en; // stage_enable_bit
        logic wd_en; // watchdog enable
        logic wake_prev; // last wake input state
        logic hall_prev; // last hall state
        logic [7:0] rdata; // read data
        logic reg_on; // regulator on
        logic reg_limited; // regulator current limited
        logic rst_out_n; // reset output to the controller
        logic stages; // power stages enabled
        logic bus_en; // bus transceiver enabled
        logic bus_armed; // bus wake detection armed
        logic wd_run; // watchdog running
    } st_type;
    // regulator is up during the reset phase, reset output held low
    localparam st_type ST_RESET = '{mode: MODE_RESET, reg_on: 1'b1, default: '0};
    st_type s_reg;
    st_type s_next;
    // helper links
    pulse_link_if wake_lnk ();
    pulse_link_if irq_lnk ();
    logic irq_trig; // new enabled flag this cycle
    // ==================================================================
    // helpers
    wake_filter u_wake_filter (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_arm(s_reg.bus_armed),
        .lnk(wake_lnk.dst)
    );
    irq_pulse_gen u_irq_pulse_gen (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .lnk(irq_lnk.dst)
    );
    assign wake_lnk.trigger = i_bus_dominant;
    assign irq_lnk.trigger = irq_trig;
    // ==================================================================
    // combinational decode
    logic detect_on; // detectors run in normal request and normal
    logic wake_chg; // wake input state changed
    logic hall_chg; // hall state changed
    logic bus_wake; // qualified bus wake from the filter
    logic wr_ifr;
    logic wr_sys;
    logic wr_rsr;
    logic wr_imr;
    logic sleep_cmd; // sleep bit written
    logic stop_cmd; // stop bit written
    always_comb begin
        detect_on = (s_reg.mode == MODE_NORM_REQ) || (s_reg.mode == MODE_NORMAL);
        wake_chg = i_wake_input_state_flag != s_reg.wake_prev;
        hall_chg = i_hall_state_flag != s_reg.hall_prev;
        bus_wake = wake_lnk.pulse;
        wr_imr = i_reg_wr && (i_reg_addr == ADDR_IMR);
        wr_ifr = i_reg_wr && (i_reg_addr == ADDR_IFR);
        wr_sys = i_reg_wr && (i_reg_addr == ADDR_SYSCTL);
        wr_rsr = i_reg_wr && (i_reg_addr == ADDR_RSR);
        sleep_cmd = wr_sys && i_reg_wdata[BIT_SLEEP];
        stop_cmd = wr_sys && i_reg_wdata[BIT_STOP];
    end
    // ==================================================================
    // next state
    logic [NUM_SRC-1:0] set_v; // hardware sets
    logic [NUM_SRC-1:0] clr_v; // software clears
    logic [1:0] wk_set; // wake sources seen in sleep
    always_comb begin
        s_next = s_reg;
        set_v = '0;
        clr_v = '0;
        wk_set = 2'h0;
        s_next.wake_prev = i_wake_input_state_flag;
        s_next.hall_prev = i_hall_state_flag;
        // flag sources
        set_v[BIT_UNDERVOLT] = detect_on && i_undervolt;
        set_v[BIT_OVERVOLT] = detect_on && i_overvolt;
        set_v[BIT_OVER_TEMP] = detect_on && i_over_temp;
        set_v[BIT_BUS_WAKE] = (s_reg.mode == MODE_STOP) && s_reg.en[BIT_BUS_WAKE]
            && bus_wake;
        set_v[BIT_HALL] = detect_on && i_hall_mode_ok && hall_chg;
        set_v[BIT_WAKE_INPUT] = wake_chg && (detect_on
            || ((s_reg.mode == MODE_STOP) && s_reg.en[BIT_WAKE_INPUT]));
        // write one clears, zero does nothing
        if (wr_ifr) begin
            clr_v = i_reg_wdata[NUM_SRC-1:0];
        end
        // a live condition keeps its flag
        clr_v[BIT_UNDERVOLT] = clr_v[BIT_UNDERVOLT] && !i_undervolt;
        clr_v[BIT_OVERVOLT] = clr_v[BIT_OVERVOLT] && !i_overvolt;
        clr_v[BIT_OVER_TEMP] = clr_v[BIT_OVER_TEMP] && !i_over_temp;
        // set wins over a clear in the same cycle
        s_next.flag = (s_reg.flag & ~clr_v) | set_v;
        // read-only: follows the individual fault flags
        s_next.flag[BIT_STAGE_FAULT] = detect_on && (|i_stage_fault);
        // enables
        if (wr_imr) begin
            s_next.en = i_reg_wdata[NUM_SRC-1:0];
        end
        // wake source flags, cleared only by one
        if (wr_rsr) begin
            s_next.wkf = s_reg.wkf & ~i_reg_wdata[1:0];
        end
        if (wr_sys) begin
            s_next.stage_en = i_reg_wdata[BIT_STAGE_EN];
            s_next.wd_en = i_reg_wdata[BIT_WD_EN];
        end
        // mode sequencing
        case (s_reg.mode)
            MODE_RESET: begin
                // hold reset output low for the reset time
                if (s_reg.cnt >= CNT_W'(RESET_HOLD - 1)) begin
                    s_next.mode = MODE_NORM_REQ;
                    s_next.cnt = '0;
                end else begin
                    s_next.cnt = s_reg.cnt + 1'b1;
                end
            end
            MODE_NORM_REQ: begin
                if (sleep_cmd) begin
                    s_next.mode = MODE_SLEEP;
                end else if (s_next.stage_en) begin
                    s_next.mode = MODE_NORMAL;
                    s_next.cnt = '0;
                end else if (!i_monitor_disable
                        && (s_reg.cnt >= CNT_W'(STARTUP_CYCLES - 1))) begin
                    s_next.mode = MODE_SLEEP;
                end else if (!i_monitor_disable) begin
                    s_next.cnt = s_reg.cnt + 1'b1;
                end
            end
            MODE_NORMAL: begin
                if (sleep_cmd) begin
                    s_next.mode = MODE_SLEEP;
                end else if (stop_cmd) begin
                    s_next.mode = MODE_STOP;
                    s_next.stage_en = 1'b0;
                end
            end
            MODE_STOP: begin
                // controller must restart the stages before drawing current
                if (sleep_cmd) begin
                    s_next.mode = MODE_SLEEP;
                end else if (wr_sys && i_reg_wdata[BIT_STAGE_EN]) begin
                    s_next.mode = MODE_NORMAL;
                end
            end
            MODE_SLEEP: begin
                // neither source can be masked here
                wk_set[BIT_WAKE_INPUT_WAKEUP] = wake_chg;
                wk_set[BIT_BUS_ACTIVITY_WAKEUP] = bus_wake;
                if (wk_set != 2'h0) begin
                    s_next.mode = MODE_RESET;
                    s_next.cnt = '0;
                    s_next.en = IMR_RESET;
                    s_next.flag = IFR_RESET;
                    s_next.stage_en = 1'b0;
                    s_next.wd_en = 1'b0;
                end
            end
            default: begin
                s_next.mode = MODE_RESET;
                s_next.cnt = '0;
            end
        endcase
        // sleep and stop entry drop the stage enable
        if (s_next.mode == MODE_SLEEP || s_next.mode == MODE_STOP) begin
            s_next.stage_en = 1'b0;
        end
        s_next.wkf = s_next.wkf | wk_set;
        // pin levels follow the next mode
        s_next.reg_on = s_next.mode != MODE_SLEEP;
        s_next.reg_limited = s_next.mode == MODE_STOP;
        s_next.rst_out_n = !(s_next.mode == MODE_RESET || s_next.mode == MODE_SLEEP);
        s_next.stages = s_next.mode == MODE_NORMAL;
        s_next.bus_en = s_next.mode == MODE_NORMAL;
        s_next.bus_armed = s_next.mode == MODE_STOP || s_next.mode == MODE_SLEEP;
        s_next.wd_run = (s_next.mode == MODE_NORMAL) && s_next.wd_en;
        // read data register, reserved bits zero
        if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_IMR: s_next.rdata = {1'b0, s_reg.en};
                ADDR_IFR: s_next.rdata = {1'b0, s_reg.flag};
                ADDR_SYSCTL: s_next.rdata = {4'h0, s_reg.wd_en,
                    s_reg.mode == MODE_SLEEP, s_reg.mode == MODE_STOP, s_reg.stage_en};
                ADDR_RSR: s_next.rdata = {6'h00, s_reg.wkf};
                default: s_next.rdata = 8'h00;
            endcase
        end
    end
    // new flag while enabled starts one pulse
    assign irq_trig = |(s_next.flag & ~s_reg.flag & s_reg.en);
    // ==================================================================
    // state register
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            s_reg <= ST_RESET;
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end
    // ==================================================================
    // outputs, all flip-flops
    assign o_reg_rdata = s_reg.rdata;
    assign o_irq = irq_lnk.pulse;
    assign o_regulator_on = s_reg.reg_on;
    assign o_regulator_limited = s_reg.reg_limited;
    assign o_reset_n = s_reg.rst_out_n;
    assign o_stages_enable = s_reg.stages;
    assign o_bus_enable = s_reg.bus_en;
    assign o_bus_wake_armed = s_reg.bus_armed;
    assign o_watchdog_run = s_reg.wd_run;
    // ==================================================================
    // assertions
    localparam int IRQ_LAT_MIN = 1;
    localparam int IRQ_LAT_MAX = 1;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);
    sequence s_new_flag;
        i_ce && irq_trig;
    endsequence
    sequence s_irq_pulse;
        o_irq [*4] ##1 (!o_irq || $past(irq_trig, 1) || $past(irq_trig, 2)
            || $past(irq_trig, 3) || $past(irq_trig, 4));
    endsequence
    property p_sleep_pins;
        s_reg.mode == MODE_SLEEP |-> !o_regulator_on && !o_reset_n && o_bus_wake_armed;
    endproperty
    a_sleep_pins: assert property (p_sleep_pins) else $error("sleep pins wrong");
    property p_sleep_entry;
        i_ce && sleep_cmd && s_reg.mode == MODE_NORMAL |=> s_reg.mode == MODE_SLEEP;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep entry");
    property p_sleep_wake;
        i_ce && s_reg.mode == MODE_SLEEP && (wake_chg || bus_wake)
            |=> s_reg.mode == MODE_RESET && s_reg.wkf != 2'h0 && s_reg.en == '0;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake lost");
    property p_normreq_pins;
        s_reg.mode == MODE_NORM_REQ |-> o_reset_n && !o_stages_enable && !o_bus_enable;
    endproperty
    a_normreq_pins: assert property (p_normreq_pins) else $error("normreq pins");
    property p_stop_pins;
        s_reg.mode == MODE_STOP |-> o_regulator_limited && o_reset_n && !o_watchdog_run
            && !o_stages_enable;
    endproperty
    a_stop_pins: assert property (p_stop_pins) else $error("stop pins wrong");
    property p_irq_pulse;
        s_new_flag |-> ##[IRQ_LAT_MIN:IRQ_LAT_MAX] s_irq_pulse;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse wrong");
    property p_enables_cleared;
        $rose(i_nrst) |-> s_reg.en == '0 && s_reg.flag == '0;
    endproperty
    a_enables_cleared: assert property (p_enables_cleared) else $error("enables set");
    property p_undervolt_held;
        i_ce && detect_on && i_undervolt |=> s_reg.flag[BIT_UNDERVOLT];
    endproperty
    a_undervolt_held: assert property (p_undervolt_held) else $error("uv flag lost");
    property p_stop_no_detect;
        s_reg.mode == MODE_STOP && i_ce && !s_reg.flag[BIT_OVER_TEMP]
            && !(wr_imr || wr_ifr) |=> !s_reg.flag[BIT_OVER_TEMP];
    endproperty
    a_stop_no_detect: assert property (p_stop_no_detect) else $error("ot in stop");
    property p_fault_ro;
        i_ce && detect_on |=> s_reg.flag[BIT_STAGE_FAULT] == $past(|i_stage_fault);
    endproperty
    a_fault_ro: assert property (p_fault_ro) else $error("fault flag wrong");
    property p_timeout;
        i_ce && s_reg.mode == MODE_NORM_REQ && !i_monitor_disable && !wr_sys
            && s_reg.cnt == CNT_W'(STARTUP_CYCLES - 1) |=> s_reg.mode == MODE_SLEEP;
    endproperty
    a_timeout: assert property (p_timeout) else $error("no fail-safe sleep");
    property p_bus_flag;
        i_ce && s_reg.mode == MODE_STOP && bus_wake && s_reg.en[BIT_BUS_WAKE]
            |=> s_reg.flag[BIT_BUS_WAKE];
    endproperty
    a_bus_flag: assert property (p_bus_flag) else $error("bus flag missing");
endmodule // mode_and_interrupt_unit

// *** hw/wake_filter.sv ***
// Purpose: bus wake detector, dominant phase long enough then a rising edge
// Assumes: trigger is high while the bus is dominant, synchronous to the clock
// Notes: pulse lasts one cycle, only while armed
module wake_filter (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_arm,
    pulse_link_if.dst lnk
);
    import mode_irq_pkg::*;
    typedef struct packed {
        logic [WAKE_CNT_W-1:0] cnt; // dominant length, saturating
        logic long_dom; // dominant phase already long enough
        logic pulse; // wake detected
    } wf_state_type;
    wf_state_type s_reg;
    wf_state_type s_next;
    // ==================================================================
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.pulse = 1'b0;
        if (!i_arm) begin
            // disarmed: forget any partial phase
            s_next.cnt = '0;
            s_next.long_dom = 1'b0;
        end else if (lnk.trigger) begin
            if (s_reg.cnt != '1) begin
                s_next.cnt = s_reg.cnt + 1'b1;
            end
            if (s_reg.cnt >= WAKE_CNT_W'(MIN_DOMINANT_WAKE_CYCLES - 1)) begin
                s_next.long_dom = 1'b1;
            end
        end else begin
            // rising edge: short glitches never count
            s_next.pulse = s_reg.long_dom;
            s_next.cnt = '0;
            s_next.long_dom = 1'b0;
        end
    end
    // ==================================================================
    // state register
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            s_reg <= '0;
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end
    assign lnk.pulse = s_reg.pulse;
endmodule // wake_filter

// *** shared/mode_irq_pkg.sv ***
// Purpose: shared constants and types of the mode and interrupt unit
// Assumes: one 20 MHz system clock, registers reached by an internal strobe port
// Notes: every offset, bit position, reset value and timing count lives here
package mode_irq_pkg;
    // ==================================================================
    // register offsets
    localparam logic [3:0] ADDR_IMR = 4'h9; // interrupt enables
    localparam logic [3:0] ADDR_IFR = 4'ha; // interrupt_flag_register
    localparam logic [3:0] ADDR_SYSCTL = 4'hc; // system control
    localparam logic [3:0] ADDR_RSR = 4'hd; // reset status, wake sources
    // ==================================================================
    // flag and enable bit positions, same in both registers
    localparam int BIT_UNDERVOLT = 0;
    localparam int BIT_OVERVOLT = 1;
    localparam int BIT_OVER_TEMP = 2;
    localparam int BIT_BUS_WAKE = 3;
    localparam int BIT_STAGE_FAULT = 4;
    localparam int BIT_HALL = 5;
    localparam int BIT_WAKE_INPUT = 6;
    localparam int NUM_SRC = 7; // seven interrupt sources
    // system control bits
    localparam int BIT_STAGE_EN = 0;
    localparam int BIT_STOP = 1;
    localparam int BIT_SLEEP = 2;
    localparam int BIT_WD_EN = 3;
    // reset status bits
    localparam int BIT_WAKE_INPUT_WAKEUP = 0;
    localparam int BIT_BUS_ACTIVITY_WAKEUP = 1;
    localparam int NUM_FAULT = 8; // individual power output fault flags
    // ==================================================================
    // reset values
    localparam logic [6:0] IMR_RESET = 7'h00;
    localparam logic [6:0] IFR_RESET = 7'h00;
    localparam logic [1:0] RSR_RESET = 2'h0;
    // ==================================================================
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int STARTUP_MONITOR_TIMEOUT_MS = 80;
    localparam int STARTUP_MONITOR_TIMEOUT_CYCLES = (CLK_HZ / 1000) * STARTUP_MONITOR_TIMEOUT_MS;
    localparam int RESET_HOLD_US = 1250;
    localparam int RESET_HOLD_CYCLES = (CLK_HZ / 1_000_000) * RESET_HOLD_US;
    localparam int MIN_DOMINANT_WAKE_US = 50;
    localparam int MIN_DOMINANT_WAKE_CYCLES =
        (CLK_HZ / 1_000_000) * MIN_DOMINANT_WAKE_US;
    localparam int IRQ_PULSE_CYCLES = 4;
    localparam int CNT_W = 21;
    localparam int WAKE_CNT_W = 10;
    // ==================================================================
    // operating modes
    typedef enum logic [2:0] {
        MODE_RESET,
        MODE_NORM_REQ,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP
    } mode_type;
endpackage

// *** shared/pulse_link_if.sv ***
// Purpose: trigger in, registered pulse out, between the top and its helpers
// Assumes: both ends on i_clk_sys
// Notes: src drives trigger, dst answers with pulse
interface pulse_link_if;
    logic trigger; // level or event from the top
    logic pulse; // registered answer of the helper
    modport src(output trigger, input pulse);
    modport dst(input trigger, output pulse);
endinterface
